// ---- logic/davi_pkg.sv ----
// Shared constants and types for the delta angle and delta velocity integrator.
// Assumes a single core clock; all users import the whole package.
package davi_pkg;

  // Core clock and nominal internal sample rate
  localparam int unsigned CORE_CLK_HZ = 125000000;
  localparam int unsigned SAMPLE_RATE_SPS = 2000;
  localparam int unsigned SAMPLE_PERIOD_CYC = CORE_CLK_HZ / SAMPLE_RATE_SPS;

  // Widths
  localparam int unsigned RESULT_W = 32;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 7;
  localparam int unsigned DEC_W = 16;
  localparam int unsigned AXES = 4;

  // Result saturation limits and zero values
  localparam logic [31:0] RESULT_MAX = 32'h7fffffff;
  localparam logic [31:0] RESULT_MIN = 32'h80000000;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [31:0] RESULT_ZERO = 32'h00000000;

  // Register byte addresses
  localparam logic [6:0] ADDR_Y_ANGLE_STEP_LOW = 7'h28;
  localparam logic [6:0] ADDR_Y_ANGLE_STEP_HIGH = 7'h2a;
  localparam logic [6:0] ADDR_Z_ANGLE_STEP_LOW = 7'h2c;
  localparam logic [6:0] ADDR_Z_ANGLE_STEP_HIGH = 7'h2e;
  localparam logic [6:0] ADDR_X_SPEED_STEP_LOW = 7'h30;
  localparam logic [6:0] ADDR_X_SPEED_STEP_HIGH = 7'h32;
  localparam logic [6:0] ADDR_Y_SPEED_STEP_LOW = 7'h34;
  localparam logic [6:0] ADDR_Y_SPEED_STEP_HIGH = 7'h36;

  // Axis slots inside the sample and result sets
  localparam int unsigned AX_Y_ANGLE = 0;
  localparam int unsigned AX_Z_ANGLE = 1;
  localparam int unsigned AX_X_SPEED = 2;
  localparam int unsigned AX_Y_SPEED = 3;

  // One pre-scaled sample per integrated axis
  typedef struct packed {
    logic [31:0] y_rate;
    logic [31:0] z_rate;
    logic [31:0] x_accel;
    logic [31:0] y_accel;
  } davi_sample_s;

  // Register read request
  typedef struct packed {
    logic en;
    logic [6:0] addr;
  } davi_rd_req_s;

  // Clamp a wide signed sum into the 32-bit result span
  function automatic logic [31:0] davi_sat(input logic signed [33:0] v);
    if (v > $signed({2'b00, RESULT_MAX})) begin
      davi_sat = RESULT_MAX;
    end else if (v < $signed({2'b11, RESULT_MIN})) begin
      davi_sat = RESULT_MIN;
    end else begin
      davi_sat = v[31:0];
    end
  endfunction

endpackage

// ---- logic/davi_tick.sv ----
// Internal sample clock: one-cycle tick per sample period.
// Assumes the core clock of the integrator top.
`timescale 1ns/1ps
`default_nettype none
module davi_tick #(
  parameter int unsigned PERIOD_CYC = 62500
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Tick out
  output logic tick_o
);
  import davi_pkg::*;

  logic [31:0] count;

  // Free-running divider, tick on wrap
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      count <= 32'h00000000;
      tick_o <= 1'b0;
    end else if (count == PERIOD_CYC - 1) begin
      count <= 32'h00000000;
      tick_o <= 1'b1;
    end else begin
      count <= count + 32'h00000001;
      tick_o <= 1'b0;
    end
  end
endmodule // davi_tick
`default_nettype wire

// ---- logic/davi_trap_integ.sv ----
// Trapezoidal integrator for one axis over one decimation period.
// Assumes samples already scaled so one input count is a/(2*fs) in result counts.
`timescale 1ns/1ps
`default_nettype none
module davi_trap_integ (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Sample input
  input wire logic sample_stb_i,
  input wire logic [31:0] sample_i,
  input wire logic [15:0] dec_i,
  // Result output
  output logic done_o,
  output logic [31:0] result_o
);
  import davi_pkg::*;

  logic [31:0] prev;
  logic [31:0] acc;
  logic [15:0] terms;
  logic signed [33:0] pair;
  logic [31:0] next_acc;

  // Current plus previous sample, added into the running sum
  always_comb begin
    pair = $signed({{2{sample_i[31]}}, sample_i}) + $signed({{2{prev[31]}}, prev});
    next_acc = davi_sat($signed({{2{acc[31]}}, acc}) + pair);
  end

  // Previous sample memory
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev <= RESULT_ZERO;
    end else if (sample_stb_i) begin
      prev <= sample_i;
    end
  end

  // Accumulate dec+1 pair terms, then hand off and restart
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc <= RESULT_ZERO;
      terms <= WORD_ZERO;
      done_o <= 1'b0;
      result_o <= RESULT_ZERO;
    end else if (sample_stb_i && terms >= dec_i) begin
      acc <= RESULT_ZERO;
      terms <= WORD_ZERO;
      done_o <= 1'b1;
      result_o <= next_acc;
    end else if (sample_stb_i) begin
      acc <= next_acc;
      terms <= terms + 16'h0001;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
    end
  end
endmodule // davi_trap_integ
`default_nettype wire

// ---- logic/davi_top.sv ----
// Delta angle and delta velocity integrator with its read-only result registers.
// Assumes sample, setting and read inputs come from logic on CORE_CLK_I.
// Summary of operation
// - Delta velocity is the sum over a period of current plus previous acceleration, over 2*fs.
// - Each period sums the decimation setting plus one pair terms.
// - The internal sample clock runs at a nominal 2000 samples per second.
// - Each axis result is a 32-bit twos-complement value split into high and low 16-bit words.
// - The high angle word is twos complement, zero reads zero, one count is range over 2^15.
// - The low angle word holds bits 15 to 0 of the 32-bit angle value.
// - The 32-bit value spans 0x80000000 to 0x7fffffff, one count is range over 2^31.
// - The high velocity word is twos complement over +/-100 m/s, about 0.003052 m/s a count.
// - The low velocity word carries the extra resolution bits of the 32-bit result.
// - Delta angle uses the same trapezoidal sum on gyroscope rate samples.
// - The angle range behind the scale is +/-360, 720 or 2160 degrees by model.
`timescale 1ns/1ps
`default_nettype none
module davi_top #(
  parameter int unsigned SAMPLE_PERIOD = davi_pkg::SAMPLE_PERIOD_CYC
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Sensor samples and decimation setting
  input wire davi_pkg::davi_sample_s SAMPLE_I,
  input wire logic [15:0] DECIMATION_SETTING_I,
  // Sample timing
  output logic SAMPLE_STROBE_O,
  output logic SAMPLE_READY_PIN_O,
  // Register read port
  input wire davi_pkg::davi_rd_req_s RD_REQ_I,
  output logic RD_VALID_O,
  output logic [15:0] RD_DATA_O
);
  import davi_pkg::*;

  logic tick;
  logic [31:0] samp [AXES];
  logic [31:0] integ [AXES];
  logic [AXES-1:0] done;
  logic [31:0] result [AXES];
  logic [15:0] next_rd;

  // Internal sample clock
  davi_tick #(
    .PERIOD_CYC(SAMPLE_PERIOD)
  ) u_tick (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .tick_o(tick)
  );

  // Axis slots: gyro rates feed angles, accelerations feed velocities
  assign samp[AX_Y_ANGLE] = SAMPLE_I.y_rate;
  assign samp[AX_Z_ANGLE] = SAMPLE_I.z_rate;
  assign samp[AX_X_SPEED] = SAMPLE_I.x_accel;
  assign samp[AX_Y_SPEED] = SAMPLE_I.y_accel;

  // One integrator per axis, all on the same tick
  for (genvar g = 0; g < AXES; g++) begin : g_axis
    davi_trap_integ u_integ (
      .clk_i(CORE_CLK_I),
      .rstn_i(RSTN_I),
      .sample_stb_i(tick),
      .sample_i(samp[g]),
      .dec_i(DECIMATION_SETTING_I),
      .done_o(done[g]),
      .result_o(integ[g])
    );
  end

  // Result set loads as a whole so both halves of a read belong together
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      for (int i = 0; i < AXES; i++) begin
        result[i] <= RESULT_ZERO;
      end
    end else if (done[0]) begin
      for (int i = 0; i < AXES; i++) begin
        result[i] <= integ[i];
      end
    end
  end

  // Sample strobe and data-ready pulse, one cycle each
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SAMPLE_STROBE_O <= 1'b0;
      SAMPLE_READY_PIN_O <= 1'b0;
    end else begin
      SAMPLE_STROBE_O <= tick;
      SAMPLE_READY_PIN_O <= done[0];
    end
  end

  // Read decode; unmapped addresses read zero
  always_comb begin
    next_rd = WORD_ZERO;
    if (RD_REQ_I.addr == ADDR_Y_ANGLE_STEP_LOW) begin
      next_rd = result[AX_Y_ANGLE][15:0];
    end else if (RD_REQ_I.addr == ADDR_Y_ANGLE_STEP_HIGH) begin
      next_rd = result[AX_Y_ANGLE][31:16];
    end else if (RD_REQ_I.addr == ADDR_Z_ANGLE_STEP_LOW) begin
      next_rd = result[AX_Z_ANGLE][15:0];
    end else if (RD_REQ_I.addr == ADDR_Z_ANGLE_STEP_HIGH) begin
      next_rd = result[AX_Z_ANGLE][31:16];
    end else if (RD_REQ_I.addr == ADDR_X_SPEED_STEP_LOW) begin
      next_rd = result[AX_X_SPEED][15:0];
    end else if (RD_REQ_I.addr == ADDR_X_SPEED_STEP_HIGH) begin
      next_rd = result[AX_X_SPEED][31:16];
    end else if (RD_REQ_I.addr == ADDR_Y_SPEED_STEP_LOW) begin
      next_rd = result[AX_Y_SPEED][15:0];
    end else if (RD_REQ_I.addr == ADDR_Y_SPEED_STEP_HIGH) begin
      next_rd = result[AX_Y_SPEED][31:16];
    end
  end

  // Registered read answer, one cycle after the request
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RD_VALID_O <= 1'b0;
      RD_DATA_O <= WORD_ZERO;
    end else begin
      RD_VALID_O <= RD_REQ_I.en;
      RD_DATA_O <= RD_REQ_I.en ? next_rd : WORD_ZERO;
    end
  end
endmodule // davi_top
`default_nettype wire

// ---- tb/davi_monitor.sv ----
// Checker for the integrator's read port and sample timing pulses.
// Sees only the top module's ports; bound from the testbench file.
`timescale 1ns/1ps
`default_nettype none
module davi_monitor #(
  parameter int SAMPLE_PERIOD = 8
) (
  // Clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RSTN_I,
  // Watched ports
  input wire logic [15:0] DECIMATION_SETTING_I,
  input wire logic SAMPLE_STROBE_O,
  input wire logic SAMPLE_READY_PIN_O,
  input wire davi_pkg::davi_rd_req_s RD_REQ_I,
  input wire logic RD_VALID_O,
  input wire logic [15:0] RD_DATA_O
);
  import davi_pkg::*;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Read port answers
  property p_rd_answer; RD_REQ_I.en |=> RD_VALID_O; endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
  property p_rd_idle; !RD_REQ_I.en |=> !RD_VALID_O && RD_DATA_O == 16'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("idle read port busy");
  property p_unmapped;
    RD_REQ_I.en && (RD_REQ_I.addr < 7'h28 || RD_REQ_I.addr > 7'h36 || RD_REQ_I.addr[0])
      |=> RD_DATA_O == 16'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Sample timing
  property p_period; SAMPLE_STROBE_O |-> ##SAMPLE_PERIOD SAMPLE_STROBE_O; endproperty
  a_period: assert property (p_period) else $error("sample period wrong");
  property p_ready_follows; SAMPLE_READY_PIN_O |-> $past(SAMPLE_STROBE_O); endproperty
  a_ready_follows: assert property (p_ready_follows) else $error("ready without strobe");
  property p_ready_gap; SAMPLE_READY_PIN_O |-> !SAMPLE_STROBE_O; endproperty
  a_ready_gap: assert property (p_ready_gap) else $error("ready on strobe cycle");
  property p_dec0;
    SAMPLE_STROBE_O && DECIMATION_SETTING_I == 16'h0 && $past(DECIMATION_SETTING_I) == 16'h0
      |=> SAMPLE_READY_PIN_O;
  endproperty
  a_dec0: assert property (p_dec0) else $error("no update at zero decimation");
  property p_ready_pulse; SAMPLE_READY_PIN_O |=> !SAMPLE_READY_PIN_O; endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready longer than one cycle");
endmodule // davi_monitor
`default_nettype wire

// ---- tb/davi_host.sv ----
// Host model: issues single reads on the integrator's read port.
// Assumes the answer stands for the one cycle after the request edge.
`timescale 1ns/1ps
`default_nettype none
module davi_host (
  // Clock
  input wire logic clk_i,
  // Read port
  output var davi_pkg::davi_rd_req_s rd_req_o,
  input wire logic rd_valid_i,
  input wire logic [15:0] rd_data_i
);
  import davi_pkg::*;
  initial rd_req_o = '0;
  // One request edge, answer taken in the following cycle
  task automatic read(input logic [6:0] a, output logic [15:0] d, output logic v);
    @(negedge clk_i);
    rd_req_o = {1'b1, a};
    @(negedge clk_i);
    d = rd_data_i;
    v = rd_valid_i;
    rd_req_o = {1'b0, ~a}; // Released address shows no stale value
  endtask
endmodule // davi_host
`default_nettype wire

// ---- tb/testbench.sv ----
// Testbench: reset values, then table of steady-state integrals, then rate and restart cases.
// Assumes a short sample period so each decimation period lasts 8 to 32 clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import davi_pkg::*;
  localparam int SP = 8;
  typedef struct packed { logic [15:0] dec; davi_sample_s s; } davi_row_s;
  logic clk = 0, rst_n = 0, strb, rdy, vld;
  davi_sample_s samp = '0;
  logic [15:0] dec = '0, rd;
  logic [31:0] e;
  davi_rd_req_s req;
  int bad_count = 0, n_tests = 0, cyc = 0, k;
  // Setting, then samples y_rate, z_rate, x_accel, y_accel
  davi_row_s rows [4] = '{'{16'h0, '{32'h5, 32'hfffffffd, 32'h100, 32'h1}},
    '{16'h1, '{32'h12345, 32'h7, 32'hffff0000, 32'h2}},
    '{16'h3, '{32'h40000000, 32'hc0000000, 32'h0, 32'h1000}},
    '{16'h2, '{32'hfffedcba, 32'h3, 32'h7, 32'habc}}};
  logic [6:0] hi_addr [4] = '{7'h2a, 7'h2e, 7'h32, 7'h36};
  davi_top #(.SAMPLE_PERIOD(SP)) davi_top_i (.CORE_CLK_I(clk), .RSTN_I(rst_n),
    .SAMPLE_I(samp), .DECIMATION_SETTING_I(dec), .SAMPLE_STROBE_O(strb),
    .SAMPLE_READY_PIN_O(rdy), .RD_REQ_I(req), .RD_VALID_O(vld), .RD_DATA_O(rd));
  davi_host davi_host_i (.clk_i(clk), .rd_req_o(req), .rd_valid_i(vld), .rd_data_i(rd));
  // Steady period sum: d plus one terms of twice the sample, clamped to 32 bits
  function automatic logic [31:0] expv(input logic [15:0] d, input logic [31:0] s);
    longint v;
    v = 2 * (longint'(d) + 1) * longint'($signed(s));
    if (v > 64'sh7fffffff) return 32'h7fffffff;
    if (v < -64'sh80000000) return 32'h80000000;
    return v[31:0];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic ok;
    davi_host_i.read(a, d, ok);
    chk(d, exp);
    chk({15'h0, ok}, 16'h1);
  endtask
  // Wait until a result update has been shown
  task automatic wrdy();
    k = 0;
    do @(negedge clk); while (rdy !== 1'b1 && ++k < 200);
  endtask
  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  initial forever #4 clk = ~clk;
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      complete_run();
    end
  end
  initial begin
    repeat (4) @(negedge clk);
    rst_n = 1;
    rdchk(7'h2a, 16'h0);
    rdchk(7'h26, 16'h0);
    for (int i = 0; i < 4; i++) begin
      samp = rows[i].s;
      dec = rows[i].dec;
      // A period in flight and the next one may still hold old samples
      wrdy();
      wrdy();
      wrdy();
      for (int a = 0; a < 4; a++) begin
        e = expv(rows[i].dec, rows[i].s[127-32*a -: 32]);
        rdchk(hi_addr[a], e[31:16]);
        rdchk(hi_addr[a] - 7'h2, e[15:0]);
      end
    end
    // Update spacing at zero decimation
    dec = 16'h0;
    wrdy();
    wrdy();
    chk(k[15:0], 16'(SP - 1));
    // Restart: previous sample cleared, both words from one update
    rst_n = 0;
    samp = '0;
    samp.y_accel = 32'h12345;
    dec = 16'h1;
    repeat (2) @(negedge clk);
    rst_n = 1;
    rdchk(7'h36, 16'h0);
    wrdy();
    rdchk(7'h36, 16'h3);
    rdchk(7'h34, 16'h69cf);
    complete_run();
  end
endmodule // testbench
`default_nettype wire
bind davi_top davi_monitor #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) davi_monitor_i (
  .CORE_CLK_I(CORE_CLK_I), .RSTN_I(RSTN_I), .DECIMATION_SETTING_I(DECIMATION_SETTING_I),
  .SAMPLE_STROBE_O(SAMPLE_STROBE_O), .SAMPLE_READY_PIN_O(SAMPLE_READY_PIN_O),
  .RD_REQ_I(RD_REQ_I), .RD_VALID_O(RD_VALID_O), .RD_DATA_O(RD_DATA_O));
